// *** verilog/rcp_pkg.sv ***
// How it works
// - a request with zero count is accepted but does nothing
// - any non-zero count runs the operation exactly once
// - queue and clear sub-fields of the control code are ignored
// - only close-pulse-on code 0x41 operates a point; master must send it
// - any control code that differs from 0x41 outside the queue and clear bits is rejected
// - on-time and off-time are ignored; valid pulse acts at once
// - an accepted command answers status 0
// - a malformed or invalid control code answers status 3
// - a point disabled by configuration answers status 4 on operate
// - binary output status reads always return zero
// - three breaker health counters are 32-bit, rolling over at 4294967295
// - three trip counters are 16-bit, rolling over at 65535
// - counter groups are cleared by local clear inputs; health counters 0 and 1 also through reset point 0x0c
// - one shared copy per counter; local and network clears both act
// - counters two to five cannot be cleared from the network
package rcp_pkg;

  localparam int RCP_NUM_POINTS = 16;
  localparam int RCP_NUM_PHASES = 3;
  localparam int RCP_NUM_COUNTERS = 6;

  // control code layout
  localparam logic [7:0] RCP_CODE_PULSE_ON = 8'h41;
  localparam logic [7:0] RCP_CODE_QC_MASK = 8'h30;

  // response status codes
  localparam logic [7:0] RCP_ST_ACCEPTED = 8'h00;
  localparam logic [7:0] RCP_ST_FORMAT_ERR = 8'h03;
  localparam logic [7:0] RCP_ST_UNSUPPORTED = 8'h04;

  // point indices with an effect on counters
  localparam logic [7:0] RCP_PT_RESET_BRK_DUTY = 8'h0c;

  // counter rollover points
  localparam logic [31:0] RCP_HEALTH_ROLL = 32'hffffffff;
  localparam logic [15:0] RCP_TRIPS_ROLL = 16'hffff;
  // highest counter index that the network may clear
  localparam int RCP_NET_CLR_LAST = 1;
  // counter index layout: health first, trips from this index, nothing from the end on
  localparam logic [2:0] RCP_TRIPS_BASE = 3'h3;
  localparam logic [2:0] RCP_CNT_END = 3'h6;

  // register byte offsets
  localparam logic [7:0] RCP_REG_POINT_EN = 8'h00;
  localparam logic [7:0] RCP_REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] RCP_REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] RCP_REG_LAST_RESP = 8'h0c;
  localparam logic [7:0] RCP_REG_CNT_SEL = 8'h10;
  localparam logic [7:0] RCP_REG_CNT_DATA = 8'h14;

  // reset values
  localparam logic [15:0] RCP_POINT_EN_RST = 16'hffff;
  localparam logic [3:0] RCP_IRQ_MASK_RST = 4'h0;

  // interrupt status bit positions
  localparam int RCP_IRQ_ACCEPT = 0;
  localparam int RCP_IRQ_FORMAT = 1;
  localparam int RCP_IRQ_UNSUP = 2;
  localparam int RCP_IRQ_ROLL = 3;
  localparam int RCP_IRQ_W = 4;

  typedef struct packed {
    logic [7:0] point;
    logic [7:0] code;
    logic [7:0] count;
    logic [31:0] on_time;
    logic [31:0] off_time;
  } rcp_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] point;
  } rcp_resp_t;

endpackage

// *** verilog/rcp_handler.sv ***
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
module rcp_handler
  import rcp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control requests from the protocol parser
  input wire logic cmd_valid,
  input wire rcp_cmd_t cmd,
  output logic resp_valid,
  output rcp_resp_t resp,
  output logic [RCP_NUM_POINTS-1:0] point_pulse,
  // binary output status reads
  input wire logic bo_rd_req,
  input wire logic [7:0] bo_rd_point,
  output logic bo_rd_valid,
  output logic bo_rd_state,
  // counters
  input wire logic [RCP_NUM_PHASES-1:0] health_inc,
  input wire logic [RCP_NUM_PHASES-1:0] trips_inc,
  input wire logic local_clr_health,
  input wire logic local_clr_trips,
  input wire logic freeze_req,
  input wire logic freeze_clr_req,
  input wire logic [2:0] cnt_rd_idx,
  output logic [31:0] cnt_rd_data,
  output logic [31:0] frozen_rd_data,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // one increment with wrap at the rollover point
  function automatic logic [31:0] rcp_bump(input logic [31:0] val, input logic [31:0] roll);
    rcp_bump = (val == roll) ? 32'h00000000 : val + 32'h00000001;
  endfunction

  function automatic logic [31:0] rcp_cnt_pick(input logic [31:0] h [RCP_NUM_PHASES],
                                               input logic [15:0] t [RCP_NUM_PHASES],
                                               input logic [2:0] idx);
    if (idx < RCP_TRIPS_BASE) begin
      rcp_cnt_pick = h[idx[1:0]];
    end else if (idx < RCP_CNT_END) begin
      rcp_cnt_pick = {16'h0000, t[2'(idx - RCP_TRIPS_BASE)]};
    end else begin
      rcp_cnt_pick = 32'h00000000;
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [RCP_NUM_POINTS-1:0] point_en;
  logic [RCP_IRQ_W-1:0] irq_status;
  logic [RCP_IRQ_W-1:0] irq_mask;
  logic [2:0] cnt_sel;
  logic [31:0] health [RCP_NUM_PHASES];
  logic [15:0] trips [RCP_NUM_PHASES];
  logic [31:0] health_frz [RCP_NUM_PHASES];
  logic [15:0] trips_frz [RCP_NUM_PHASES];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire take_cmd = clk_en & cmd_valid;
  wire cnt_zero = (cmd.count == 8'h00);
  wire [7:0] code_core = cmd.code & ~RCP_CODE_QC_MASK;
  wire code_ok = (code_core == RCP_CODE_PULSE_ON);
  wire point_in_map = (cmd.point < 8'(RCP_NUM_POINTS));
  wire point_allowed = point_in_map & point_en[cmd.point[3:0]];
  // count ignored beyond non-zero, one shot
  wire do_operate = take_cmd & ~cnt_zero & code_ok & point_allowed;
  wire fmt_err = take_cmd & ~cnt_zero & ~code_ok;
  wire unsup = take_cmd & ~cnt_zero & code_ok & ~point_allowed;
  wire accepted = take_cmd & ~fmt_err & ~unsup;
  wire [7:0] next_status = fmt_err ? RCP_ST_FORMAT_ERR : (unsup ? RCP_ST_UNSUPPORTED : RCP_ST_ACCEPTED);

  // health counters cleared through their reset point
  wire net_clr_health = do_operate & (cmd.point == RCP_PT_RESET_BRK_DUTY);

  // ---------------------------------------------------------------
  // response and point pulses
  // ---------------------------------------------------------------
  // timing fields unused, pulse acts now
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      point_pulse <= '0;
    end else if (clk_en) begin
      point_pulse <= do_operate ? (RCP_NUM_POINTS'(1) << cmd.point[3:0]) : '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else if (clk_en) begin
      resp_valid <= cmd_valid;
      if (cmd_valid) begin
        resp.status <= next_status;
        resp.point <= cmd.point;
      end
    end
  end

  // ---------------------------------------------------------------
  // binary output reads
  // ---------------------------------------------------------------
  // point index is not needed: every pulse point reads as off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bo_rd_valid <= 1'b0;
    end else if (clk_en) begin
      bo_rd_valid <= bo_rd_req;
    end
  end
  assign bo_rd_state = 1'b0;

  // ---------------------------------------------------------------
  // shared counters
  // ---------------------------------------------------------------
  // clear beats increment in the same cycle; one copy serves every interface
  wire [RCP_NUM_PHASES-1:0] health_clr;
  for (genvar i = 0; i < RCP_NUM_PHASES; i++) begin : g_cnt
    // network reaches only the low counters
    wire net_clr = net_clr_health & (i <= RCP_NET_CLR_LAST);
    // local and network clear one shared copy
    assign health_clr[i] = local_clr_health | net_clr;
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        health[i] <= '0;
      end else if (clk_en & health_clr[i]) begin
        health[i] <= '0;
      end else if (clk_en & health_inc[i]) begin
        health[i] <= rcp_bump(health[i], RCP_HEALTH_ROLL);
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        trips[i] <= '0;
      end else if (clk_en & local_clr_trips) begin
        trips[i] <= '0;
      end else if (clk_en & trips_inc[i]) begin
        trips[i] <= 16'(rcp_bump({16'h0000, trips[i]}, {16'h0000, RCP_TRIPS_ROLL}));
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        health_frz[i] <= '0;
        trips_frz[i] <= '0;
      end else if (clk_en & (freeze_req | freeze_clr_req)) begin
        health_frz[i] <= health[i];
        trips_frz[i] <= trips[i];
      end
    end
  end

  wire [RCP_NUM_PHASES-1:0] health_wrap;
  wire [RCP_NUM_PHASES-1:0] trips_wrap;
  for (genvar j = 0; j < RCP_NUM_PHASES; j++) begin : g_wrap
    // a clear in the same cycle wins, so no wrap is flagged then
    assign health_wrap[j] = health_inc[j] & ~health_clr[j] & (health[j] == RCP_HEALTH_ROLL);
    assign trips_wrap[j] = trips_inc[j] & ~local_clr_trips & (trips[j] == RCP_TRIPS_ROLL);
  end
  wire roll_evt = clk_en & (|health_wrap | |trips_wrap);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_rd_data <= '0;
      frozen_rd_data <= '0;
    end else if (clk_en) begin
      cnt_rd_data <= rcp_cnt_pick(health, trips, cnt_rd_idx);
      frozen_rd_data <= rcp_cnt_pick(health_frz, trips_frz, cnt_rd_idx);
    end
  end

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  wire apb_acc = psel & penable & clk_en;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  wire sel_point_en = (paddr == RCP_REG_POINT_EN);
  wire sel_irq_status = (paddr == RCP_REG_IRQ_STATUS);
  wire sel_irq_mask = (paddr == RCP_REG_IRQ_MASK);
  wire sel_last_resp = (paddr == RCP_REG_LAST_RESP);
  wire sel_cnt_sel = (paddr == RCP_REG_CNT_SEL);
  wire sel_cnt_data = (paddr == RCP_REG_CNT_DATA);
  wire mapped = sel_point_en | sel_irq_status | sel_irq_mask | sel_last_resp | sel_cnt_sel | sel_cnt_data;

  // no wait states; only the access phase carries an answer
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic [31:0] rd_mux;
  always_comb begin
    if (sel_point_en) begin
      rd_mux = {16'h0000, point_en};
    end else if (sel_irq_status) begin
      rd_mux = {28'h0000000, irq_status};
    end else if (sel_irq_mask) begin
      rd_mux = {28'h0000000, irq_mask};
    end else if (sel_last_resp) begin
      rd_mux = {16'h0000, resp.point, resp.status};
    end else if (sel_cnt_sel) begin
      rd_mux = {29'h00000000, cnt_sel};
    end else if (sel_cnt_data) begin
      rd_mux = rcp_cnt_pick(health, trips, cnt_sel);
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // read data flop
  // ---------------------------------------------------------------
  // caught at the setup edge, dropped when the access completes;
  // limitation: clk_en must be high in the setup cycle of a read
  wire apb_rd_setup = psel & ~penable & ~pwrite & clk_en;
  logic [31:0] rd_hold;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_hold <= '0;
    end else if (apb_rd_setup) begin
      rd_hold <= rd_mux;
    end else if (apb_acc) begin
      rd_hold <= '0;
    end
  end
  assign prdata = rd_hold;

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  wire wr_point_en = apb_wr & sel_point_en;
  wire wr_irq_mask = apb_wr & sel_irq_mask;
  wire wr_cnt_sel = apb_wr & sel_cnt_sel;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      point_en <= RCP_POINT_EN_RST;
    end else if (wr_point_en) begin
      point_en <= pwdata[RCP_NUM_POINTS-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= RCP_IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= pwdata[RCP_IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_sel <= '0;
    end else if (wr_cnt_sel) begin
      cnt_sel <= pwdata[$bits(cnt_sel)-1:0];
    end
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  logic [RCP_IRQ_W-1:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[RCP_IRQ_ACCEPT] = accepted;
    irq_set[RCP_IRQ_FORMAT] = fmt_err;
    irq_set[RCP_IRQ_UNSUP] = unsup;
    irq_set[RCP_IRQ_ROLL] = roll_evt;
  end

  // read clears, but an event in the same cycle survives
  wire irq_rd_clr = apb_rd & sel_irq_status;
  // only bits already reported in the read data are cleared, so nothing set after the setup edge is lost
  wire [RCP_IRQ_W-1:0] irq_seen = irq_rd_clr ? rd_hold[RCP_IRQ_W-1:0] : '0;
  wire [RCP_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_seen) | irq_set;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // rcp_handler

// *** verification/rcp_handler_asserts.sv ***
`timescale 1ns/10ps
module rcp_handler_asserts
  import rcp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire rcp_cmd_t cmd,
  input wire logic resp_valid,
  input wire rcp_resp_t resp,
  input wire logic [15:0] point_pulse,
  input wire logic bo_rd_req,
  input wire logic bo_rd_valid,
  input wire logic bo_rd_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic code_ok;
  // qc bits masked before the compare
  assign code_ok = (cmd.code & ~RCP_CODE_QC_MASK) == RCP_CODE_PULSE_ON;
  sequence s_take;
    cmd_valid && clk_en;
  endsequence
  sequence s_live;
    s_take ##0 cmd.count != 8'h00;
  endsequence
  answer_follows_a: assert property (s_take |=> resp_valid && resp.point == $past(cmd.point))
    else $error("no answer after request");
  zero_count_a: assert property (s_take ##0 cmd.count == 8'h00 |=> !resp.status && !point_pulse)
    else $error("zero count acted");
  bad_code_a: assert property (s_live ##0 !code_ok |=> resp.status == RCP_ST_FORMAT_ERR && !point_pulse)
    else $error("bad code not refused");
  qc_ignored_a: assert property (s_live ##0 code_ok |=> resp.status != RCP_ST_FORMAT_ERR)
    else $error("queue or clear bits used");
  far_point_a: assert property (s_live ##0 code_ok && cmd.point > 8'h0f |=> resp.status == RCP_ST_UNSUPPORTED)
    else $error("far point not unsupported");
  act_now_a: assert property (s_live ##0 code_ok && cmd.point < 8'h10 |=>
    resp.status == RCP_ST_UNSUPPORTED || point_pulse[$past(cmd.point[3:0])])
    else $error("pulse not immediate");
  one_pulse_a: assert property (point_pulse != '0 |-> $onehot(point_pulse) && resp_valid && !resp.status)
    else $error("pulse not single");
  bo_zero_a: assert property (bo_rd_req && clk_en |=> bo_rd_valid && !bo_rd_state)
    else $error("output status not zero");
endmodule // rcp_handler_asserts

bind rcp_handler rcp_handler_asserts u_chk (.ref_clk, .rst, .clk_en, .cmd_valid, .cmd, .resp_valid, .resp,
  .point_pulse, .bo_rd_req, .bo_rd_valid, .bo_rd_state);

// *** verification/rcp_master.sv ***
`timescale 1ns/10ps
module rcp_master
  import rcp_pkg::*;
(
  input wire logic ref_clk,
  output logic cmd_valid,
  output rcp_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(input logic [7:0] pt, input logic [7:0] code, input logic [7:0] cnt);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{pt, code, cnt, 32'h0000_0007, 32'hffff_fff0};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    // stale fields inverted so idle never looks valid
    cmd <= ~cmd;
  endtask
endmodule // rcp_master

// *** verification/rcp_handler_tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module rcp_handler_tb;
  import rcp_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, bo_rd_req = 0;
  logic local_clr_health = 0, local_clr_trips = 0, freeze_req = 0, freeze_clr_req = 0;
  logic [7:0] paddr = '0, bo_rd_point = '0;
  logic [31:0] pwdata = '0, prdata, cnt_rd_data, frozen_rd_data, rdq;
  logic pready, pslverr, cmd_valid, resp_valid, bo_rd_valid, bo_rd_state, irq, rerr;
  logic [2:0] health_inc = '0, trips_inc = '0, cnt_rd_idx = '0;
  logic [15:0] point_pulse;
  rcp_cmd_t cmd;
  rcp_resp_t resp;
  int n_fail = 0, comparisons = 0;
  logic [7:0] cds [7] = '{8'h41, 8'h71, 8'h01, 8'h81, 8'h40, 8'h42, 8'hc1};

  rcp_handler DUT (.ref_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_valid, .cmd, .resp_valid, .resp, .point_pulse, .bo_rd_req, .bo_rd_point, .bo_rd_valid,
    .bo_rd_state, .health_inc, .trips_inc, .local_clr_health, .local_clr_trips, .freeze_req,
    .freeze_clr_req, .cnt_rd_idx, .cnt_rd_data, .frozen_rd_data, .irq);
  rcp_master m (.ref_clk, .cmd_valid, .cmd);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // ----
  // bus and check helpers
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [7:0] pt, code, cnt, st, input logic [15:0] pl);
    m.send(pt, code, cnt);
    #1;
    `CHK("resp_valid", 1'b1, resp_valid)
    `CHK("status", st, resp.status)
    `CHK("point", pt, resp.point)
    `CHK("pulse", pl, point_pulse)
  endtask
  task automatic rc(input logic [2:0] i, input logic [31:0] e);
    @(posedge ref_clk);
    cnt_rd_idx <= i;
    @(posedge ref_clk);
    #1;
    `CHK("counter", e, cnt_rd_data)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_cmds;
    apb(1'b0, RCP_REG_POINT_EN, '0);
    `CHK("point_en", 32'h0000ffff, rdq)
    `CHK("slverr", 1'b0, rerr)
    apb(1'b0, 8'h18, '0);
    `CHK("unmapped", 1'b1, rerr)
    `CHK("unmapped data", 32'h00000000, rdq)
    op(8'h07, 8'h41, 8'h00, 8'h00, 16'h0000);
    op(8'h07, 8'h41, 8'hff, 8'h00, 16'h0080);
    for (int i = 0; i < 7; i++) begin
      op(8'h05, cds[i], 8'h01, (i < 2) ? 8'h00 : 8'h03, (i < 2) ? 16'h0020 : 16'h0000);
    end
    apb(1'b1, RCP_REG_POINT_EN, 32'h0000fff7);
    op(8'h03, 8'h41, 8'h01, 8'h04, 16'h0000);
    op(8'h14, 8'h41, 8'h01, 8'h04, 16'h0000);
    apb(1'b0, RCP_REG_LAST_RESP, '0);
    `CHK("last resp", 32'h00001404, rdq)
    apb(1'b1, RCP_REG_POINT_EN, 32'h0000ffff);
    @(posedge ref_clk);
    bo_rd_req <= 1'b1;
    bo_rd_point <= 8'h01;
    @(posedge ref_clk);
    bo_rd_req <= 1'b0;
    #1;
    `CHK("bo_valid", 1'b1, bo_rd_valid)
    `CHK("bo_state", 1'b0, bo_rd_state)
    apb(1'b0, RCP_REG_IRQ_STATUS, '0);
    `CHK("irq bits", 32'h00000007, rdq)
    op(8'h09, 8'h41, 8'h01, 8'h00, 16'h0200);
    #1;
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, RCP_REG_IRQ_MASK, 32'h00000001);
    #1;
    `CHK("irq", 1'b1, irq)
    apb(1'b0, RCP_REG_IRQ_STATUS, '0);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    $display("commands done");
  endtask
  task automatic t_hold;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    health_inc <= 3'h4;
    m.send(8'h02, 8'h41, 8'h01);
    #1;
    `CHK("held resp", 1'b0, resp_valid)
    `CHK("held pulse", 16'h0000, point_pulse)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    health_inc <= '0;
    rc(3'h2, 32'h0);
    $display("clock enable done");
  endtask
  task automatic t_cnt;
    @(posedge ref_clk);
    health_inc <= 3'h7;
    trips_inc <= 3'h7;
    freeze_clr_req <= 1'b1;
    @(posedge ref_clk);
    health_inc <= '0;
    trips_inc <= '0;
    @(posedge ref_clk);
    freeze_clr_req <= 1'b0;
    for (int i = 0; i < 6; i++) rc(i[2:0], 32'h1);
    `CHK("frozen", 32'h1, frozen_rd_data)
    apb(1'b1, RCP_REG_CNT_SEL, 32'h00000004);
    apb(1'b0, RCP_REG_CNT_SEL, '0);
    `CHK("cnt_sel", 32'h00000004, rdq)
    apb(1'b0, RCP_REG_CNT_DATA, '0);
    `CHK("cnt_data", 32'h00000001, rdq)
    op(8'h0c, 8'h41, 8'h01, 8'h00, 16'h1000);
    rc(3'h0, 32'h0);
    rc(3'h1, 32'h0);
    rc(3'h2, 32'h1);
    rc(3'h3, 32'h1);
    @(posedge ref_clk);
    local_clr_health <= 1'b1;
    local_clr_trips <= 1'b1;
    @(posedge ref_clk);
    local_clr_health <= 1'b0;
    local_clr_trips <= 1'b0;
    rc(3'h2, 32'h0);
    rc(3'h5, 32'h0);
    @(posedge ref_clk);
    trips_inc <= 3'h1;
    repeat (65537) @(posedge ref_clk);
    trips_inc <= '0;
    rc(3'h3, 32'h1);
    apb(1'b0, RCP_REG_IRQ_STATUS, '0);
    `CHK("roll flag", 1'b1, rdq[RCP_IRQ_ROLL])
    @(posedge ref_clk);
    freeze_req <= 1'b1;
    @(posedge ref_clk);
    freeze_req <= 1'b0;
    rc(3'h3, 32'h1);
    `CHK("frozen trips", 32'h1, frozen_rd_data)
    rc(3'h0, 32'h0);
    `CHK("frozen health", 32'h0, frozen_rd_data)
    $display("counters done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_cmds;
    t_hold;
    t_cnt;
    report_and_stop;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end
endmodule // rcp_handler_tb
